// ===== adc_consts.vh
`ifndef ADC_CONSTS_VH
`define ADC_CONSTS_VH

// Result and serial frame widths
`define ADC_RES_BITS 12
`define ADC_SER_BITS 4'hC
`define ADC_FIFO_DEPTH 4

// Byte-lane split of the parallel bus
`define ADC_HI_MSB 11
`define ADC_HI_LSB 4
`define ADC_LO_MSB 3
`define ADC_LO_FILL 4'h0

// Timing, system clock 10 MHz
`define ADC_CLK_PERIOD_NS 100
`define ADC_SCLK_HALF_NS 200
`define ADC_SCLK_HALF_CYC (`ADC_SCLK_HALF_NS / `ADC_CLK_PERIOD_NS)

// Pin synchroniser lanes
`define ADC_SYNC_W 9
`define ADC_SY_CS 0
`define ADC_SY_RC 1
`define ADC_SY_BYTE 2
`define ADC_SY_CSEL 3
`define ADC_SY_FMT 4
`define ADC_SY_PD 5
`define ADC_SY_REFERENCE_DISABLE 6
`define ADC_SY_SCLK 7
`define ADC_SY_CASC 8
// Synchroniser reset: chip select and read/convert idle high, rest low
`define ADC_SYNC_IDLE 9'h003

`endif

// ===== adc_host_if.v
`timescale 1ns/1ps
`default_nettype none
`include "adc_consts.vh"

// Small synchronous FIFO between the converter core and the result latch
module result_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  // Honest flags straight from the occupancy count
  assign in_ready_o = (cnt_r != DEPTH[AW:0]);
  assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
  assign out_data_o = mem_r[rd_r];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Pointers wrap only for power-of-two depths
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (ce_i) begin
      if (push) begin
        mem_r[wr_r] <= in_data_i;
        wr_r <= wr_r + 1'b1;
      end
      if (pop)
        rd_r <= rd_r + 1'b1;
      if (push & ~pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // result_fifo

module adc_host_if #(
  parameter SCLK_HALF = `ADC_SCLK_HALF_CYC
) (
  input wire CLOCK_I,
  input wire RST_I,
  input wire CE_I,
  input wire CS_N_I,
  input wire READ_CONVERT_I,
  input wire BYTE_SEL_I,
  input wire CLOCK_SOURCE_SEL_I,
  input wire CODE_FORMAT_SEL_I,
  input wire ANALOG_POWERDOWN_I,
  input wire REFERENCE_DISABLE_I,
  input wire SERIAL_BIT_CLOCK_I,
  output wire SERIAL_BIT_CLOCK_O,
  output wire SERIAL_BIT_CLOCK_OE_O,
  input wire CASCADE_IN_I,
  output wire SERIAL_OUT_O,
  output wire [7:0] PARALLEL_OUT_O,
  output wire PARALLEL_OE_O,
  output wire BUSY_N_O,
  output wire CORE_START_O,
  input wire [`ADC_RES_BITS-1:0] CORE_DATA_I,
  input wire CORE_DONE_I,
  output wire CORE_READY_O,
  output wire ANALOG_EN_O,
  output wire REFERENCE_EN_O
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_LOAD = 2'h2;
  localparam ST_DRAIN = 2'h3;
  localparam [`ADC_SYNC_W-1:0] SYNC_IDLE = `ADC_SYNC_IDLE;

  // Two's complement from the core, MSB flipped for straight binary
  function [`ADC_RES_BITS-1:0] fmt_code;
    input [`ADC_RES_BITS-1:0] d;
    input sb;
    begin
      fmt_code = {d[`ADC_RES_BITS-1] ^ sb, d[`ADC_RES_BITS-2:0]};
    end
  endfunction

  reg [`ADC_SYNC_W-1:0] meta_r;
  reg [`ADC_SYNC_W-1:0] sync_r;
  reg act_prev_r;
  reg sclk_prev_r;
  reg [1:0] state_r;
  reg busy_n_r;
  reg start_r;
  reg [`ADC_RES_BITS-1:0] result_r;
  reg [7:0] par_r;
  reg par_oe_r;
  reg [`ADC_RES_BITS-1:0] sh_r;
  reg [3:0] bits_r;
  reg ser_act_r;
  reg sclk_r;
  reg sclk_oe_r;
  reg [7:0] div_r;
  reg casc_r;
  reg ana_en_r;
  reg ref_en_r;
  reg fifo_in_ready_r;
  wire cs_n;
  wire rc;
  wire act;
  wire start_req;
  wire ext_clk;
  wire ext_rise;
  wire ext_fall;
  wire int_tick;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [`ADC_RES_BITS-1:0] fifo_out_data;
  wire [`ADC_RES_BITS-1:0] code;
  reg [1:0] state_nxt;

  // Two-flop synchronisers for every pin input
  genvar g;
  generate
    for (g = 0; g < `ADC_SYNC_W; g = g + 1) begin : g_sync
      always @(posedge CLOCK_I) begin
        if (RST_I) begin
          meta_r[g] <= SYNC_IDLE[g]; // Idle level, so no false edge
          sync_r[g] <= SYNC_IDLE[g];
        end else if (CE_I) begin
          meta_r[g] <= (g == `ADC_SY_CS) ? CS_N_I :
                       (g == `ADC_SY_RC) ? READ_CONVERT_I :
                       (g == `ADC_SY_BYTE) ? BYTE_SEL_I :
                       (g == `ADC_SY_CSEL) ? CLOCK_SOURCE_SEL_I :
                       (g == `ADC_SY_FMT) ? CODE_FORMAT_SEL_I :
                       (g == `ADC_SY_PD) ? ANALOG_POWERDOWN_I :
                       (g == `ADC_SY_REFERENCE_DISABLE) ? REFERENCE_DISABLE_I :
                       (g == `ADC_SY_SCLK) ? SERIAL_BIT_CLOCK_I :
                       CASCADE_IN_I;
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign cs_n = sync_r[`ADC_SY_CS];
  assign rc = sync_r[`ADC_SY_RC];
  assign ext_clk = sync_r[`ADC_SY_CSEL];
  // Both inputs act as one level; whichever falls last starts
  assign act = ~cs_n & ~rc;
  assign start_req = act & ~act_prev_r & (state_r == ST_IDLE);
  assign ext_rise = ext_clk & sync_r[`ADC_SY_SCLK] & ~sclk_prev_r;
  assign ext_fall = ext_clk & ~sync_r[`ADC_SY_SCLK] & sclk_prev_r;
  assign int_tick = (div_r == SCLK_HALF[7:0] - 8'h01);
  assign code = fmt_code(result_r, sync_r[`ADC_SY_FMT]);
  // Hold the result latch steady while the host reads the bus
  assign fifo_out_ready = (state_r == ST_LOAD) & ~par_oe_r;

  // Conversion sequence: busy drops at start, rises once latch and
  // internal serial frame are both done
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_req)
          state_nxt = ST_CONV;
      end
      ST_CONV: begin
        if (CORE_DONE_I & fifo_in_ready)
          state_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        if (fifo_out_valid & fifo_out_ready)
          state_nxt = ST_DRAIN;
      end
      ST_DRAIN: begin
        if (~ser_act_r)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Control state, busy and result latch
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      state_r <= ST_IDLE;
      busy_n_r <= 1'b1;
      start_r <= 1'b0;
      act_prev_r <= 1'b0;
      sclk_prev_r <= 1'b0;
      result_r <= {`ADC_RES_BITS{1'b0}};
      ana_en_r <= 1'b1;
      ref_en_r <= 1'b1;
    end else if (CE_I) begin
      state_r <= state_nxt;
      busy_n_r <= (state_nxt == ST_IDLE);
      start_r <= start_req;
      act_prev_r <= act;
      sclk_prev_r <= sync_r[`ADC_SY_SCLK];
      if (fifo_out_valid & fifo_out_ready)
        result_r <= fifo_out_data;
      ana_en_r <= ~sync_r[`ADC_SY_PD];
      ref_en_r <= ~sync_r[`ADC_SY_REFERENCE_DISABLE];
    end
  end

  // Parallel bus: enabled only with chip select low and read/convert high
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      par_r <= 8'h00;
      par_oe_r <= 1'b0;
    end else if (CE_I) begin
      par_oe_r <= ~cs_n & rc;
      if (~cs_n & rc) begin
        if (sync_r[`ADC_SY_BYTE])
          par_r <= {code[`ADC_LO_MSB:0], `ADC_LO_FILL};
        else
          par_r <= code[`ADC_HI_MSB:`ADC_HI_LSB];
      end else begin
        par_r <= 8'h00;
      end
    end
  end

  // Serial shifter; the frame starts with the conversion so it carries
  // the previous result, and in external mode the cascade bits follow
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      sh_r <= {`ADC_RES_BITS{1'b0}};
      bits_r <= 4'h0;
      ser_act_r <= 1'b0;
      sclk_r <= 1'b0;
      sclk_oe_r <= 1'b0;
      div_r <= 8'h00;
      casc_r <= 1'b0;
    end else if (CE_I) begin
      sclk_oe_r <= ~ext_clk;
      if (start_req) begin
        sh_r <= code;
        bits_r <= `ADC_SER_BITS;
        ser_act_r <= ~ext_clk;
        sclk_r <= 1'b0;
        div_r <= 8'h00;
      end else if (ext_clk) begin
        // Host clock: sample cascade on rise, shift on fall
        ser_act_r <= 1'b0;
        sclk_r <= 1'b0;
        if (ext_rise)
          casc_r <= sync_r[`ADC_SY_CASC];
        if (ext_fall)
          sh_r <= {sh_r[`ADC_RES_BITS-2:0], casc_r};
      end else if (ser_act_r) begin
        // Internal clock: one bit per full period, MSB first
        div_r <= int_tick ? 8'h00 : div_r + 8'h01;
        if (int_tick) begin
          sclk_r <= ~sclk_r;
          if (sclk_r) begin
            sh_r <= {sh_r[`ADC_RES_BITS-2:0], 1'b0};
            bits_r <= bits_r - 4'h1;
            if (bits_r == 4'h1)
              ser_act_r <= 1'b0;
          end
        end
      end
    end
  end

  result_fifo #(
    .WIDTH(`ADC_RES_BITS),
    .DEPTH(`ADC_FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .in_data_i(CORE_DATA_I),
    .in_valid_i(CORE_DONE_I & (state_r == ST_CONV)),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready)
  );

  // All outputs straight from flip-flops
  assign SERIAL_BIT_CLOCK_O = sclk_r;
  assign SERIAL_BIT_CLOCK_OE_O = sclk_oe_r;
  assign SERIAL_OUT_O = sh_r[`ADC_RES_BITS-1];
  assign PARALLEL_OUT_O = par_r;
  assign PARALLEL_OE_O = par_oe_r;
  assign BUSY_N_O = busy_n_r;
  assign CORE_START_O = start_r;
  assign CORE_READY_O = fifo_in_ready_r;
  assign ANALOG_EN_O = ana_en_r;
  assign REFERENCE_EN_O = ref_en_r;

  // Registered copy of FIFO space for the core handshake
  always @(posedge CLOCK_I) begin
    if (RST_I)
      fifo_in_ready_r <= 1'b1;
    else if (CE_I)
      fifo_in_ready_r <= fifo_in_ready;
  end
endmodule // adc_host_if
`default_nettype wire

// ===== adc_host_if_pad.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== adc_host_if_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adc_host_if_asserts (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic CS_N_I,
  input wire logic READ_CONVERT_I,
  input wire logic BYTE_SEL_I,
  input wire logic CLOCK_SOURCE_SEL_I,
  input wire logic ANALOG_POWERDOWN_I,
  input wire logic REFERENCE_DISABLE_I,
  input wire logic SERIAL_BIT_CLOCK_OE_O,
  input wire logic [7:0] PARALLEL_OUT_O,
  input wire logic PARALLEL_OE_O,
  input wire logic BUSY_N_O,
  input wire logic CORE_START_O,
  input wire logic ANALOG_EN_O,
  input wire logic REFERENCE_EN_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // Taken start: busy drops with the core pulse
  sequence s_start;
    $fell(BUSY_N_O) ##0 CORE_START_O;
  endsequence
  // Five samples cover the synchroniser and output register
  sequence s_off;
    (CS_N_I || !READ_CONVERT_I) [*5];
  endsequence
  a_start_busy: assert property (
    CORE_START_O |-> $fell(BUSY_N_O))
    else $error("core start without busy falling");
  a_start_once: assert property (
    s_start |=> (!CORE_START_O && !BUSY_N_O) [*3])
    else $error("start pulse or busy too short");
  a_busy_ignore: assert property (
    !BUSY_N_O && !$past(BUSY_N_O) |-> !CORE_START_O)
    else $error("start taken while busy");
  a_bus_off: assert property (s_off |-> !PARALLEL_OE_O)
    else $error("parallel bus driven while off");
  a_lo_fill: assert property (
    BYTE_SEL_I [*5] ##0 PARALLEL_OE_O |-> PARALLEL_OUT_O[3:0] == 4'h0)
    else $error("low nibble not cleared");
  a_clk_ext: assert property (
    CLOCK_SOURCE_SEL_I [*5] |-> !SERIAL_BIT_CLOCK_OE_O)
    else $error("bit clock driven in external mode");
  a_pwr_off: assert property (
    ANALOG_POWERDOWN_I [*5] |-> !ANALOG_EN_O)
    else $error("analog left on");
  a_ref_off: assert property (
    REFERENCE_DISABLE_I [*5] |-> !REFERENCE_EN_O)
    else $error("reference left on");
endmodule // adc_host_if_asserts
bind adc_host_if adc_host_if_asserts chk (
  .CLOCK_I(CLOCK_I),
  .RST_I(RST_I),
  .CS_N_I(CS_N_I),
  .READ_CONVERT_I(READ_CONVERT_I),
  .BYTE_SEL_I(BYTE_SEL_I),
  .CLOCK_SOURCE_SEL_I(CLOCK_SOURCE_SEL_I),
  .ANALOG_POWERDOWN_I(ANALOG_POWERDOWN_I),
  .REFERENCE_DISABLE_I(REFERENCE_DISABLE_I),
  .SERIAL_BIT_CLOCK_OE_O(SERIAL_BIT_CLOCK_OE_O),
  .PARALLEL_OUT_O(PARALLEL_OUT_O),
  .PARALLEL_OE_O(PARALLEL_OE_O),
  .BUSY_N_O(BUSY_N_O),
  .CORE_START_O(CORE_START_O),
  .ANALOG_EN_O(ANALOG_EN_O),
  .REFERENCE_EN_O(REFERENCE_EN_O)
);
`default_nettype wire

// ===== adc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic ready_i,
  input wire logic [7:0] lat_i,
  input wire logic [11:0] word_i,
  output var logic done_o,
  output var logic [11:0] data_o
);
  int wait_r = 0;
  initial done_o = 1'h0;
  initial data_o = 12'h000;
  // Settle lat_i cycles, then offer the word until the FIFO takes it
  always @(posedge clk_i) begin
    if (start_i) begin
      wait_r <= lat_i;
    end else if (wait_r > 1) begin
      wait_r <= wait_r - 1;
    end else if (wait_r == 1) begin
      wait_r <= 0;
      done_o <= 1'h1;
      data_o <= word_i;
    end else if (done_o && ready_i) begin
      done_o <= 1'h0;
      data_o <= ~data_o; // Released: stale value must not pass
    end
  end
endmodule // adc_core_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'h0, rst = 1'h1, cs_n = 1'h1, rc = 1'h1, bsel = 1'h0;
  logic csel = 1'h0, fmt = 1'h0, pd = 1'h0, reference_disable = 1'h0;
  logic sclk = 1'h0, casc = 1'h0, have = 1'h0;
  logic [11:0] word = 12'h000, prev = 12'h000, cdata, s, c, cq = 12'h000;
  logic [7:0] lat = 8'h01, pout;
  logic sclk_o, sclk_oe, sout, poe, busy_n, cstart, cdone, cready, aen, ren;
  logic [11:0] res_q[$];
  int errors = 0, checked = 0, cycles = 0, seed = 19373, n;
  int starts = 0, convs = 0;
  wire sclk_pin;
  // Shared bit clock wire: whoever enables drives it
  assign sclk_pin = sclk_oe ? sclk_o : sclk;
  always #50 clk = ~clk;
  adc_host_if uut (
    .CLOCK_I(clk), .RST_I(rst), .CE_I(1'h1), .CS_N_I(cs_n),
    .READ_CONVERT_I(rc), .BYTE_SEL_I(bsel), .CLOCK_SOURCE_SEL_I(csel),
    .CODE_FORMAT_SEL_I(fmt), .ANALOG_POWERDOWN_I(pd),
    .REFERENCE_DISABLE_I(reference_disable), .SERIAL_BIT_CLOCK_I(sclk_pin),
    .SERIAL_BIT_CLOCK_O(sclk_o), .SERIAL_BIT_CLOCK_OE_O(sclk_oe),
    .CASCADE_IN_I(casc), .SERIAL_OUT_O(sout), .PARALLEL_OUT_O(pout),
    .PARALLEL_OE_O(poe), .BUSY_N_O(busy_n), .CORE_START_O(cstart),
    .CORE_DATA_I(cdata), .CORE_DONE_I(cdone), .CORE_READY_O(cready),
    .ANALOG_EN_O(aen), .REFERENCE_EN_O(ren));
  adc_core_model core (.clk_i(clk), .start_i(cstart), .ready_i(cready),
    .lat_i(lat), .word_i(word), .done_o(cdone), .data_o(cdata));
  // Reference queue of raw words handed over by the core
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cstart) starts <= starts + 1;
    if (cdone && cready) res_q.push_back(cdata);
    if (cycles == 6000) begin
      errors++;
      conclude();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Output coding as the host should see it
  function automatic logic [11:0] code(input logic [11:0] d);
    code = fmt ? {~d[11], d[10:0]} : d;
  endfunction
  // One conversion, its serial frame, then both bytes read back
  task automatic conv(input logic ext);
    word <= 12'($random(seed));
    // Slow enough that the mid-busy start always meets a busy core
    lat <= 8'h08 + 8'({$random(seed)} % 40);
    fmt <= 1'($random(seed));
    pd <= 1'($random(seed));
    reference_disable <= 1'($random(seed));
    csel <= ext;
    convs++;
    n = $random(seed) & 1;
    {cs_n, rc} <= n ? 2'h1 : 2'h2;
    tick(6);
    {cs_n, rc} <= 2'h0;
    for (n = 0; n < 9 && busy_n !== 1'h0; n++) tick(1);
    chk(busy_n, 1'h0);
    s = 12'h000;
    cs_n <= 1'h1;
    // Busy already low: this second start must be ignored
    if (ext) begin
      tick(3);
      cs_n <= 1'h0;
      tick(4);
      cs_n <= 1'h1;
    end
    for (int i = 0; i < 12; i++) begin
      if (ext) begin
        cq = {cq[10:0], 1'($random(seed))};
        casc <= cq[0];
        tick(4);
        s = {s[10:0], sout};
        sclk <= 1'h1;
        tick(4);
        sclk <= 1'h0;
      end else begin
        for (n = 0; n < 9 && sclk_o !== 1'h0; n++) @(negedge clk);
        for (n = 0; n < 9 && sclk_o !== 1'h1; n++) @(negedge clk);
        s = {s[10:0], sout};
      end
    end
    tick(4);
    if (have) chk(s, code(prev));
    for (n = 0; n < 300 && busy_n !== 1'h1; n++) tick(1);
    chk(busy_n, 1'h1);
    if (ext) chk(sout, cq[11]);
    chk(sclk_oe, !ext);
    chk(aen, !pd);
    chk(ren, !reference_disable);
    chk(starts, convs);
    prev = res_q.size() ? res_q.pop_front() : 12'hxxx;
    have = 1'h1;
    c = code(prev);
    {cs_n, rc, bsel} <= 3'h2;
    tick(5);
    chk(poe, 1'h1);
    chk(pout, c[11:4]);
    bsel <= 1'h1;
    tick(5);
    chk(pout, {c[3:0], 4'h0});
    cs_n <= 1'h1;
    tick(5);
    chk(poe, 1'h0);
  endtask
  task automatic conclude;
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Reset, then two internal bit clock runs before each external one
  initial begin
    tick(8);
    rst <= 1'h0;
    tick(4);
    for (int k = 0; k < 12; k++) conv(k % 3 == 2);
    conclude();
  end
endmodule // testbench
`default_nettype wire
